//--- shared/fceu_regs.svh
/*
 * Register map, entry field layout and conversion constants of the feedback
 * conversion entry unit. Assumes inclusion by bare name from design files.
 */
`ifndef FCEU_REGS_SVH
`define FCEU_REGS_SVH

`define FCEU_ENTRY_COUNT 8
`define FCEU_IDX_W 3
`define FCEU_LAST_IDX 3'h7
`define FCEU_SRC_W 24
`define FCEU_RES_W 32

`define FCEU_METHOD_HI 23
`define FCEU_METHOD_LO 20
`define FCEU_SRC_ADDR_HI 15
`define FCEU_SRC_ADDR_LO 0
`define FCEU_SUM_BIT 16
`define FCEU_UNSIGNED_BIT 19
`define FCEU_SHIFT_HI 19
`define FCEU_SHIFT_LO 18

`define FCEU_METHOD_AD_PLAIN 4'h1
`define FCEU_METHOD_AD_INTEG 4'h5
`define FCEU_METHOD_PAR_Y 4'h2
`define FCEU_METHOD_PAR_Y_FILT 4'h3
`define FCEU_METHOD_PAR_X 4'h6
`define FCEU_METHOD_PAR_X_FILT 4'h7

`define FCEU_SHIFT_NONE 2'h2
`define FCEU_SHIFT_RIGHT 2'h3

`define FCEU_AD_WORD_HI 23
`define FCEU_AD_WORD_LO 8

`define FCEU_TABLE_END 8'h80
`define FCEU_ENTRY_HI 6
`define FCEU_ENTRY_LO 4
`define FCEU_SEL_HI 3
`define FCEU_SEL_LO 2
`define FCEU_SEL_LINE1 2'h0
`define FCEU_SEL_LINE2 2'h1
`define FCEU_SEL_LINE3 2'h2
`define FCEU_SEL_RESULT 2'h3
`define FCEU_REG_CTRL 8'h80
`define FCEU_REG_STATUS 8'h84
`define FCEU_REG_CYCLES 8'h88
`define FCEU_CTRL_ENABLE_BIT 0
`define FCEU_STATUS_BUSY_BIT 0
`define FCEU_STATUS_OVERRUN_BIT 1

`endif

//--- shared/fceu_pkg.sv
/*
 * Types shared by the feedback conversion entry unit.
 * Assumes nothing of its surroundings.
 */
package fceu_pkg;
	typedef enum logic [1:0] {
		FCEU_IDLE,
		FCEU_READ,
		FCEU_CALC
	} fceu_state_t;
	typedef logic [23:0] fceu_word_t;
	typedef logic signed [31:0] fceu_result_t;
	typedef logic signed [25:0] fceu_delta_t;
endpackage

//--- src/fceu_sat_add.sv
/*
 * Saturating signed adder for converter-style integration.
 * Assumes both operands are 32-bit two's complement values.
 */
`timescale 1ns/10ps
module fceu_sat_add (
	input wire fceu_pkg::fceu_result_t a_in,
	input wire fceu_pkg::fceu_result_t b_in,
	output logic signed [31:0] sum_out
);
	import fceu_pkg::*;

	logic signed [32:0] wide;

	always_comb begin
		wide = {a_in[31], a_in} + {b_in[31], b_in};
		if (wide[32] != wide[31]) begin
			sum_out = wide[32] ? {1'b1, 31'h0} : {1'b0, {31{1'b1}}};
		end else begin
			sum_out = wide[31:0];
		end
	end
endmodule

//--- src/fceu_par_delta.sv
/*
 * Masked change of a parallel source word since the last servo cycle,
 * extended across rollover and optionally limited per cycle.
 * Assumes the mask is a contiguous run of ones from bit 0.
 */
`timescale 1ns/10ps
module fceu_par_delta (
	input wire fceu_pkg::fceu_word_t src_in,
	input wire fceu_pkg::fceu_word_t prev_in,
	input wire fceu_pkg::fceu_word_t mask_in,
	input wire fceu_pkg::fceu_word_t limit_in,
	input wire logic filter_in,
	output fceu_pkg::fceu_word_t masked_out,
	output fceu_pkg::fceu_delta_t delta_out
);
	import fceu_pkg::*;

	fceu_word_t diff;
	fceu_word_t top;
	fceu_delta_t raw;
	fceu_delta_t lim;

	always_comb begin
		masked_out = src_in & mask_in;
		diff = (masked_out - prev_in) & mask_in;
		top = mask_in & ~(mask_in >> 1);
		lim = {2'h0, limit_in};
		if (|(diff & top)) begin
			raw = {2'h0, diff} - ({2'h0, mask_in} + 26'h1);
		end else begin
			raw = {2'h0, diff};
		end
		delta_out = raw;
		if (filter_in) begin
			if (raw > lim) begin
				delta_out = lim;
			end else if (raw < -lim) begin
				delta_out = -lim;
			end
		end
	end
endmodule

//--- src/fceu_conversion_core.sv
/*
 * Feedback conversion entry unit: a table of setup entries processed once
 * per servo cycle into scaled position results, with an Avalon-MM slave.
 * Assumes a source register port that returns data one clock after a read.
 */
`timescale 1ns/10ps
`include "fceu_regs.svh"
// Function
// - Converter entries take upper 16 source bits, shifted so LSB lands at bit 5.
// - Converter entries saturate and never extend across rollover.
// - Integrating converter adds bias-corrected shifted reading to previous result.
// - Entry bit 19 picks signed (0) or unsigned (1) converter value.
// - Bias is signed, in 1/256 converter LSB, subtracted before integrating.
// - Unsigned converter reading is clamped at zero after bias correction.
// - Parallel entries read the address in the first line's low 16 bits.
// - Method digit picks Y or X space and filtered three-line use.
// - Second digit picks left five, none or right three, with optional summing.
// - Normal shift puts source LSB at result bit 5.
// - Right shift moves source bit 8 to result bit 5.
// - No shift copies source LSB to result bit 0.
// - Summing adds the processed value to the entry above's result.
// - Source word is ANDed with the 24-bit mask before anything else.
// - Masked width detects rollover; accumulated result extends across it.
// - Filtered methods limit source change per cycle to the third line.
module fceu_conversion_core (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic servo_tick_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic src_read_out,
	output logic [15:0] src_addr_out,
	output logic src_space_x_out,
	input wire fceu_pkg::fceu_word_t src_data_in,
	output logic result_valid_out,
	output logic [2:0] result_entry_out,
	output fceu_pkg::fceu_result_t result_data_out,
	output logic busy_out
);
	import fceu_pkg::*;

	fceu_state_t state_reg;
	logic [`FCEU_IDX_W-1:0] idx_reg;
	fceu_word_t line1_reg [`FCEU_ENTRY_COUNT];
	fceu_word_t line2_reg [`FCEU_ENTRY_COUNT];
	fceu_word_t line3_reg [`FCEU_ENTRY_COUNT];
	fceu_result_t result_reg [`FCEU_ENTRY_COUNT];
	fceu_result_t accum_reg [`FCEU_ENTRY_COUNT];
	fceu_word_t prev_src_reg [`FCEU_ENTRY_COUNT];
	logic enable_reg;
	logic overrun_reg;
	logic [31:0] cycles_reg;
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic [15:0] src_addr_reg;
	logic src_space_x_reg;
	logic result_valid_reg;
	logic [2:0] result_entry_reg;
	fceu_result_t result_data_reg;

	logic start;
	logic bus_write;
	logic [`FCEU_IDX_W-1:0] bus_idx;
	logic [1:0] bus_sel;
	logic [`FCEU_IDX_W-1:0] next_idx;
	fceu_word_t line1;
	logic [3:0] method;
	logic is_ad;
	logic is_par;
	logic is_filt;
	logic [31:0] rd_mux;
	logic signed [16:0] ad_val;
	logic signed [25:0] ad_corr;
	fceu_result_t ad_plain;
	fceu_result_t ad_inc;
	fceu_result_t ad_integ;
	fceu_word_t par_masked;
	fceu_delta_t par_delta;
	fceu_result_t accum_next;
	fceu_result_t shifted;
	fceu_result_t above;
	fceu_result_t result_next;

	function automatic fceu_word_t be_merge(input fceu_word_t old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		fceu_word_t m;
		m = old_v;
		if (be[0]) begin
			m[7:0] = new_v[7:0];
		end
		if (be[1]) begin
			m[15:8] = new_v[15:8];
		end
		if (be[2]) begin
			m[23:16] = new_v[23:16];
		end
		return m;
	endfunction

	assign bus_idx = avs_address_in[`FCEU_ENTRY_HI:`FCEU_ENTRY_LO];
	assign bus_sel = avs_address_in[`FCEU_SEL_HI:`FCEU_SEL_LO];
	// A write lands at the edge where waitrequest is seen low.
	assign bus_write = avs_write_in & ack_reg;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign avs_readdata_out = readdata_reg;
	assign start = servo_tick_in & enable_reg & (state_reg == FCEU_IDLE);
	assign busy_out = (state_reg != FCEU_IDLE);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		if (avs_address_in < `FCEU_TABLE_END) begin
			unique case (bus_sel)
				`FCEU_SEL_LINE1: rd_mux = {8'h0, line1_reg[bus_idx]};
				`FCEU_SEL_LINE2: rd_mux = {8'h0, line2_reg[bus_idx]};
				`FCEU_SEL_LINE3: rd_mux = {8'h0, line3_reg[bus_idx]};
				`FCEU_SEL_RESULT: rd_mux = result_reg[bus_idx];
			endcase
		end else if (avs_address_in == `FCEU_REG_CTRL) begin
			rd_mux[`FCEU_CTRL_ENABLE_BIT] = enable_reg;
		end else if (avs_address_in == `FCEU_REG_STATUS) begin
			rd_mux[`FCEU_STATUS_BUSY_BIT] = busy_out;
			rd_mux[`FCEU_STATUS_OVERRUN_BIT] = overrun_reg;
		end else if (avs_address_in == `FCEU_REG_CYCLES) begin
			rd_mux = cycles_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			readdata_reg <= 32'h0;
		end else if (avs_read_in & ~ack_reg) begin
			readdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			enable_reg <= 1'b0;
		end else if (bus_write & avs_byteenable_in[0] & (avs_address_in == `FCEU_REG_CTRL)) begin
			enable_reg <= avs_writedata_in[`FCEU_CTRL_ENABLE_BIT];
		end
	end

	// A tick that comes while a pass is running is dropped and flagged.
	// A new overrun wins over a software clear in the same cycle.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			overrun_reg <= 1'b0;
		end else if (servo_tick_in & enable_reg & busy_out) begin
			overrun_reg <= 1'b1;
		end else if (bus_write & avs_byteenable_in[0] & (avs_address_in == `FCEU_REG_STATUS)
				& avs_writedata_in[`FCEU_STATUS_OVERRUN_BIT]) begin
			overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < `FCEU_ENTRY_COUNT; i++) begin
				line1_reg[i] <= 24'h0;
				line2_reg[i] <= 24'h0;
				line3_reg[i] <= 24'h0;
			end
		end else if (bus_write & (avs_address_in < `FCEU_TABLE_END)) begin
			unique case (bus_sel)
				`FCEU_SEL_LINE1: line1_reg[bus_idx] <=
					be_merge(line1_reg[bus_idx], avs_writedata_in, avs_byteenable_in);
				`FCEU_SEL_LINE2: line2_reg[bus_idx] <=
					be_merge(line2_reg[bus_idx], avs_writedata_in, avs_byteenable_in);
				`FCEU_SEL_LINE3: line3_reg[bus_idx] <=
					be_merge(line3_reg[bus_idx], avs_writedata_in, avs_byteenable_in);
				`FCEU_SEL_RESULT: begin
				end
			endcase
		end
	end

	assign next_idx = (state_reg == FCEU_IDLE) ? 3'h0 : idx_reg + 3'h1;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg <= FCEU_IDLE;
			idx_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				FCEU_IDLE: begin
					if (start) begin
						state_reg <= FCEU_READ;
						idx_reg <= next_idx;
					end
				end
				FCEU_READ: begin
					state_reg <= FCEU_CALC;
				end
				FCEU_CALC: begin
					if (idx_reg == `FCEU_LAST_IDX) begin
						state_reg <= FCEU_IDLE;
					end else begin
						state_reg <= FCEU_READ;
						idx_reg <= next_idx;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cycles_reg <= 32'h0;
		end else if ((state_reg == FCEU_CALC) && (idx_reg == `FCEU_LAST_IDX)) begin
			cycles_reg <= cycles_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			src_addr_reg <= 16'h0;
			src_space_x_reg <= 1'b0;
		end else if (start | ((state_reg == FCEU_CALC) && (idx_reg != `FCEU_LAST_IDX))) begin
			src_addr_reg <= line1_reg[next_idx][`FCEU_SRC_ADDR_HI:`FCEU_SRC_ADDR_LO];
			src_space_x_reg <= (line1_reg[next_idx][`FCEU_METHOD_HI:`FCEU_METHOD_LO]
				== `FCEU_METHOD_PAR_X) | (line1_reg[next_idx][`FCEU_METHOD_HI:`FCEU_METHOD_LO]
				== `FCEU_METHOD_PAR_X_FILT);
		end
	end

	assign line1 = line1_reg[idx_reg];
	assign method = line1[`FCEU_METHOD_HI:`FCEU_METHOD_LO];
	assign is_ad = (method == `FCEU_METHOD_AD_PLAIN) | (method == `FCEU_METHOD_AD_INTEG);
	assign is_filt = (method == `FCEU_METHOD_PAR_Y_FILT) | (method == `FCEU_METHOD_PAR_X_FILT);
	assign is_par = is_filt | (method == `FCEU_METHOD_PAR_Y) | (method == `FCEU_METHOD_PAR_X);
	assign src_read_out = (state_reg == FCEU_READ) & (is_ad | is_par);
	assign src_addr_out = src_addr_reg;
	assign src_space_x_out = src_space_x_reg;

	fceu_par_delta u_delta (
		.src_in(src_data_in),
		.prev_in(prev_src_reg[idx_reg]),
		.mask_in(line2_reg[idx_reg]),
		.limit_in(line3_reg[idx_reg]),
		.filter_in(is_filt),
		.masked_out(par_masked),
		.delta_out(par_delta)
	);

	fceu_sat_add u_sat (
		.a_in(result_reg[idx_reg]),
		.b_in(ad_inc),
		.sum_out(ad_integ)
	);

	always_comb begin
		if (line1[`FCEU_UNSIGNED_BIT]) begin
			ad_val = {1'b0, src_data_in[`FCEU_AD_WORD_HI:`FCEU_AD_WORD_LO]};
		end else begin
			ad_val = {src_data_in[`FCEU_AD_WORD_HI],
				src_data_in[`FCEU_AD_WORD_HI:`FCEU_AD_WORD_LO]};
		end
		ad_plain = {{10{ad_val[16]}}, ad_val, 5'h0};
		ad_corr = {ad_val[16], ad_val, 8'h0}
			- {{2{line2_reg[idx_reg][23]}}, line2_reg[idx_reg]};
		if (line1[`FCEU_UNSIGNED_BIT] & ad_corr[25]) begin
			ad_corr = 26'h0;
		end
		ad_inc = {{9{ad_corr[25]}}, ad_corr[25:3]};
	end

	always_comb begin
		accum_next = accum_reg[idx_reg] + {{6{par_delta[25]}}, par_delta};
		unique case (line1[`FCEU_SHIFT_HI:`FCEU_SHIFT_LO])
			`FCEU_SHIFT_NONE: shifted = accum_next;
			`FCEU_SHIFT_RIGHT: shifted = {{3{accum_next[31]}}, accum_next[31:3]};
			default: shifted = {accum_next[26:0], 5'h0};
		endcase
		above = (idx_reg == 3'h0) ? 32'sh0 : result_reg[idx_reg - 3'h1];
		result_next = result_reg[idx_reg];
		if (is_ad) begin
			result_next = (method == `FCEU_METHOD_AD_INTEG) ? ad_integ : ad_plain;
		end else if (is_par) begin
			result_next = line1[`FCEU_SUM_BIT] ? shifted + above : shifted;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < `FCEU_ENTRY_COUNT; i++) begin
				result_reg[i] <= 32'sh0;
				accum_reg[i] <= 32'sh0;
				prev_src_reg[i] <= 24'h0;
			end
		end else if (state_reg == FCEU_CALC) begin
			result_reg[idx_reg] <= result_next;
			if (is_par) begin
				accum_reg[idx_reg] <= accum_next;
				prev_src_reg[idx_reg] <= par_masked;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			result_valid_reg <= 1'b0;
			result_entry_reg <= 3'h0;
			result_data_reg <= 32'sh0;
		end else begin
			result_valid_reg <= (state_reg == FCEU_CALC);
			if (state_reg == FCEU_CALC) begin
				result_entry_reg <= idx_reg;
				result_data_reg <= result_next;
			end
		end
	end

	assign result_valid_out = result_valid_reg;
	assign result_entry_out = result_entry_reg;
	assign result_data_out = result_data_reg;
endmodule

//--- tb/fceu_src_model.sv
/*
 * Source register model: Y and X word banks that answer one clock after a read.
 * Assumes the bench loads the banks before it starts a servo pass.
 */
`timescale 1ns/10ps
module fceu_src_model (
	input wire logic clk_in,
	input wire logic src_read_in,
	input wire logic [15:0] src_addr_in,
	input wire logic src_space_x_in,
	output fceu_pkg::fceu_word_t src_data_out
);
	import fceu_pkg::*;
	fceu_word_t mem_y [16];
	fceu_word_t mem_x [16];
	// Outside a read the word toggles every cycle, so a late sample shows up.
	always @(posedge clk_in) begin
		if (src_read_in)
			src_data_out <= src_space_x_in ? mem_x[src_addr_in[3:0]] : mem_y[src_addr_in[3:0]];
		else
			src_data_out <= ~src_data_out;
	end
endmodule

//--- tb/fceu_conversion_core_asserts.sv
/*
 * Port checker of the conversion core: bus wait, pass timing and result order.
 * Assumes it is bound to the core and sees only its ports.
 */
`timescale 1ns/10ps
module fceu_core_chk (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic servo_tick_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic src_read_out,
	input wire logic result_valid_out,
	input wire logic [2:0] result_entry_out,
	input wire fceu_pkg::fceu_result_t result_data_out,
	input wire logic busy_out
);
	import fceu_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	chk_bus_one_wait: assert property ($rose(avs_read_in) || $rose(avs_write_in)
		|-> avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus wait not one cycle");
	chk_pass_start: assert property ($rose(busy_out) |-> $past(servo_tick_in) ##2
		(result_valid_out && result_entry_out == 3'h0)) else $error("pass start wrong");
	chk_pass_length: assert property ($rose(busy_out) |->
		busy_out [*8] ##1 busy_out [*8] ##1 !busy_out) else $error("pass length wrong");
	chk_entry_order: assert property (result_valid_out && result_entry_out != 3'h7 |->
		##2 result_valid_out && result_entry_out == $past(result_entry_out, 2) + 3'h1)
		else $error("entry order wrong");
	chk_valid_pulse: assert property (result_valid_out |=> !result_valid_out)
		else $error("result valid not a pulse");
	chk_read_to_result: assert property (src_read_out |-> ##2 result_valid_out)
		else $error("read not followed by result");
	chk_read_in_pass: assert property (src_read_out |-> busy_out)
		else $error("source read outside pass");
	chk_result_hold: assert property (!result_valid_out |->
		$stable(result_data_out) && $stable(result_entry_out)) else $error("result moved");
	chk_valid_in_pass: assert property (result_valid_out |-> $past(busy_out))
		else $error("result outside pass");
endmodule
bind fceu_conversion_core fceu_core_chk fceu_core_chk_i (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.servo_tick_in(servo_tick_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_waitrequest_out(avs_waitrequest_out),
	.src_read_out(src_read_out),
	.result_valid_out(result_valid_out),
	.result_entry_out(result_entry_out),
	.result_data_out(result_data_out),
	.busy_out(busy_out)
);

//--- tb/fceu_conversion_core_tb.sv
/*
 * Self-checking bench of the conversion core with a source register model.
 * Assumes one wait cycle per bus request and source data one clock after a read.
 */
`timescale 1ns/10ps
module fceu_conversion_core_tb;
	import fceu_pkg::*;
	typedef struct {
		logic [23:0] l1;
		logic [23:0] l2;
		logic [23:0] l3;
		logic [23:0] src;
		logic [31:0] exp;
	} fceu_row_t;
	fceu_row_t rows [12] = '{
		'{24'h100001, 24'h0, 24'h0, 24'hfff000, 32'hfffffe00},
		'{24'h180001, 24'h0, 24'h0, 24'hfff000, 32'h001ffe00},
		'{24'h500001, 24'h000500, 24'h0, 24'h001000, 32'h00000160},
		'{24'h580001, 24'h000500, 24'h0, 24'h000200, 32'h0},
		'{24'h200001, 24'h000fff, 24'h0, 24'habc123, 32'h00002460},
		'{24'h680001, 24'hffffff, 24'h0, 24'h000123, 32'h00000123},
		'{24'h2c0001, 24'hffffff, 24'h0, 24'h012345, 32'h00002468},
		'{24'h210001, 24'hffffff, 24'h0, 24'h000010, 32'h00000a00},
		'{24'h690001, 24'hffffff, 24'h0, 24'h000005, 32'h00000805},
		'{24'h2d0001, 24'hffffff, 24'h0, 24'h000800, 32'h00000900},
		// limit below, then above velocity
		// The first limit row treats its large jump as a misread; the second passes true motion.
		'{24'h300001, 24'hffffff, 24'h000010, 24'h000100, 32'h00000200},
		'{24'h780001, 24'hffffff, 24'h000004, 24'h000003, 32'h00000003}};
	logic clk_in = 1'b0;
	logic reset_in = 1'b0;
	logic servo_tick_in = 1'b0;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out, rd;
	logic avs_waitrequest_out, src_read_out, src_space_x_out, result_valid_out, busy_out;
	logic [15:0] src_addr_out;
	logic [2:0] result_entry_out;
	fceu_word_t src_data_in;
	fceu_result_t result_data_out;
	fceu_result_t res [8];
	int fail_count = 0;
	int total_checks = 0;
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) if (result_valid_out === 1'b1) res[result_entry_out] <= result_data_out;
	fceu_conversion_core fceu_conversion_core_i (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.servo_tick_in(servo_tick_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hf),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.src_read_out(src_read_out),
		.src_addr_out(src_addr_out),
		.src_space_x_out(src_space_x_out),
		.src_data_in(src_data_in),
		.result_valid_out(result_valid_out),
		.result_entry_out(result_entry_out),
		.result_data_out(result_data_out),
		.busy_out(busy_out)
	);
	fceu_src_model fceu_src_model_i (
		.clk_in(clk_in),
		.src_read_in(src_read_out),
		.src_addr_in(src_addr_out),
		.src_space_x_in(src_space_x_out),
		.src_data_out(src_data_in)
	);
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	task automatic tick;
		@(posedge clk_in);
		servo_tick_in <= 1'b1;
		@(posedge clk_in);
		servo_tick_in <= 1'b0;
	endtask
	task automatic run_pass;
		int n;
		n = 0;
		tick();
		do begin
			@(posedge clk_in);
			n++;
		end while (!(result_valid_out === 1'b1 && result_entry_out === 3'h7) && n < 40);
		if (n >= 40) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	task automatic do_reset;
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
	endtask
	// Entry 0 is a plain converter entry that summing rows build on.
	task automatic setup(input fceu_row_t r);
		logic x;
		x = (r.l1[22:21] == 2'b11);
		do_reset();
		bus(1'b1, 8'h80, 32'h1);
		bus(1'b1, 8'h00, 32'h00100000);
		bus(1'b1, 8'h10, {8'h00, r.l1});
		bus(1'b1, 8'h14, {8'h00, r.l2});
		bus(1'b1, 8'h18, {8'h00, r.l3});
		fceu_src_model_i.mem_y[0] = 24'h004000;
		fceu_src_model_i.mem_y[1] = x ? ~r.src : r.src;
		fceu_src_model_i.mem_x[1] = x ? r.src : ~r.src;
	endtask
	initial begin
		do_reset();
		bus(1'b0, 8'h80, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 8'h24, 32'hffffffff);
		bus(1'b0, 8'h24, 32'h0);
		check(rd, 32'h00ffffff);
		bus(1'b1, 8'h2c, 32'h1);
		bus(1'b0, 8'h2c, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 8'h8c, 32'h0);
		check(rd, 32'h0);
		$display("register test done");
		foreach (rows[i]) begin
			setup(rows[i]);
			run_pass();
			check(res[0], 32'h800);
			check(res[1], rows[i].exp);
			$display("row %0d done", i);
		end
		// From the stored zero, a first word just below the mask top reads as two counts down.
		setup('{24'h200001, 24'h000fff, 24'h0, 24'h000ffe, 32'h0});
		run_pass();
		check(res[1], 32'hffffffc0);
		fceu_src_model_i.mem_y[1] = 24'hfff002;
		run_pass();
		check(res[1], 32'h00000040);
		$display("rollover test done");
		setup('{24'h500001, 24'h800000, 24'h0, 24'h7fff00, 32'h0});
		repeat (1100) run_pass();
		check(res[1], 32'h7fffffff);
		bus(1'b0, 8'h1c, 32'h0);
		check(rd, 32'h7fffffff);
		$display("saturation test done");
		tick();
		repeat (3) @(posedge clk_in);
		tick();
		repeat (20) @(posedge clk_in);
		bus(1'b0, 8'h84, 32'h0);
		check(rd, 32'h2);
		bus(1'b1, 8'h84, 32'h2);
		bus(1'b0, 8'h84, 32'h0);
		check(rd, 32'h0);
		// One pass per accepted tick since the last reset: 1100 runs plus the first overrun tick.
		bus(1'b0, 8'h88, 32'h0);
		check(rd, 32'h0000044d);
		$display("overrun test done");
		tally_and_finish();
	end
endmodule
